// file: logic/stc_cfg.svh
`ifndef STC_CFG_SVH
`define STC_CFG_SVH

// Register addresses on the 8-bit I/O port
`define STC_ADDR_W        4
`define STC_A_CNT_L       4'h0
`define STC_A_CNT_H       4'h1
`define STC_A_CMPA_L      4'h2
`define STC_A_CMPA_H      4'h3
`define STC_A_CMPB_L      4'h4
`define STC_A_CMPB_H      4'h5
`define STC_A_CMPC_L      4'h6
`define STC_A_CMPC_H      4'h7
`define STC_A_CAP_L       4'h8
`define STC_A_CAP_H       4'h9
`define STC_A_CTRL_A      4'hA
`define STC_A_CTRL_B      4'hB
`define STC_A_CTRL_C      4'hC
`define STC_A_FLAG        4'hD
`define STC_A_MASK        4'hE
`define STC_A_SFC         4'hF

// Field positions
`define STC_B_WGM_LO      1:0
`define STC_B_CS          2:0
`define STC_B_WGM_HI      4:3
`define STC_B_CAP_EDGE    6
`define STC_B_CAP_FILT    7
`define STC_B_CAP_ACMP    0
`define STC_B_FORCE       7:5
`define STC_B_SYNC_HOLD   7
`define STC_B_PCLR        0
`define STC_F_CAP         0
`define STC_F_CMP         3:1
`define STC_F_OVF         4

// Reset values and constants
`define STC_RST_BYTE      8'h00
`define STC_RST_WORD      16'h0000
`define STC_BOTTOM        16'h0000
`define STC_MAX           16'hFFFF
`define STC_TOP_8         16'h00FF
`define STC_TOP_9         16'h01FF
`define STC_TOP_10        16'h03FF
`define STC_NC_SAMPLES    4

`endif

// file: logic/stc_pkg.sv
package stc_pkg;

  typedef enum logic [2:0] {
    STC_CS_STOP     = 3'b000,
    STC_CS_DIV1     = 3'b001,
    STC_CS_DIV8     = 3'b010,
    STC_CS_DIV64    = 3'b011,
    STC_CS_DIV256   = 3'b100,
    STC_CS_DIV1024  = 3'b101,
    STC_CS_EXT_FALL = 3'b110,
    STC_CS_EXT_RISE = 3'b111
  } stc_clk_sel_t;

endpackage : stc_pkg

// file: logic/stc_pin_cond.sv
`timescale 1ns/1ps
`include "stc_cfg.svh"

module stc_pin_cond #(
  parameter int SAMPLES = `STC_NC_SAMPLES
) (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic pin,
  input  wire logic filt_en,
  output logic      level_ff,
  output logic      rise_ff,
  output logic      fall_ff
);

  logic       s1_ff;
  logic       s2_ff;
  logic       s3_ff;
  logic       stab_ff;
  logic [3:0] run_ff;
  logic       nxt_stab;
  logic [3:0] nxt_run;
  logic       nxt_level;

  always_comb begin
    nxt_stab  = (s2_ff == s3_ff) ? s3_ff : stab_ff;
    nxt_run   = 4'h0;
    nxt_level = level_ff;
    if (!filt_en) begin
      nxt_level = stab_ff;
    end else if (stab_ff != level_ff) begin
      // Level only follows after a full run of equal samples
      nxt_run = run_ff + 4'h1;
      if (nxt_run >= 4'(SAMPLES)) begin
        nxt_level = stab_ff;
        nxt_run   = 4'h0;
      end
    end
  end

  always_ff @(posedge clk) begin
    s1_ff <= pin;
    s2_ff <= s1_ff;
    s3_ff <= s2_ff;
    if (srst) begin
      stab_ff  <= 1'b0;
      run_ff   <= 4'h0;
      level_ff <= 1'b0;
      rise_ff  <= 1'b0;
      fall_ff  <= 1'b0;
    end else begin
      stab_ff  <= nxt_stab;
      run_ff   <= nxt_run;
      level_ff <= nxt_level;
      rise_ff  <= nxt_level & ~level_ff;
      fall_ff  <= ~nxt_level & level_ff;
    end
  end

endmodule : stc_pin_cond

// file: logic/stc_timer_core.sv
`timescale 1ns/1ps
`include "stc_cfg.svh"

module stc_timer_core #(
  parameter int PRE_W = 10
) (
  input  wire logic                      clk,
  input  wire logic                      srst,
  input  wire logic [`STC_ADDR_W-1:0]    io_addr,
  input  wire logic [7:0]                io_wdata,
  input  wire logic                      io_we,
  input  wire logic                      io_re,
  output logic      [7:0]                io_rdata_ff,
  input  wire logic                      legacy_mode,
  input  wire logic                      external_count_pin,
  input  wire logic                      capture_input_pin,
  input  wire logic                      comparator_out,
  input  wire logic [4:0]                irq_ack,
  output logic      [4:0]                irq_req_ff,
  output logic      [2:0]                compare_match_ff,
  output logic      [2:0]                compare_output_pins_ff,
  output logic                           bottom_ff,
  output logic                           max_ff,
  output logic                           top_ff
);

  logic [15:0]      counter_value_ff;
  logic [7:0]       temp_ff;
  logic [15:0]      cmp_buf_ff [3];
  logic [15:0]      cmp_act_ff [3];
  logic [15:0]      capture_reg_ff;
  logic [7:0]       ctrl_a_ff;
  logic [7:0]       ctrl_b_ff;
  logic [7:0]       ctrl_c_ff;
  logic [4:0]       flag_ff;
  logic [4:0]       mask_ff;
  logic             sync_hold_mode_ff;
  logic             shared_prescaler_clear_ff;
  logic [PRE_W-1:0] pre_ff;
  logic             moved_ff;

  logic [15:0]      nxt_counter_value;
  logic [7:0]       nxt_temp;
  logic [15:0]      nxt_cmp_buf [3];
  logic [15:0]      nxt_cmp_act [3];
  logic [15:0]      nxt_capture_reg;
  logic [7:0]       nxt_ctrl_a;
  logic [7:0]       nxt_ctrl_b;
  logic [7:0]       nxt_ctrl_c;
  logic [4:0]       nxt_flag;
  logic [4:0]       nxt_mask;
  logic             nxt_sync_hold_mode;
  logic             nxt_shared_prescaler_clear;
  logic [PRE_W-1:0] nxt_pre;
  logic             nxt_moved;
  logic [7:0]       nxt_rdata;
  logic [2:0]       nxt_match;
  logic [2:0]       nxt_pwm;
  logic [2:0]       hit;

  logic [3:0]       wgm;
  logic [15:0]      top_val;
  logic             pwm_mode;
  logic             presc_rst;
  logic             timer_tick;
  logic [2:0]       chan_en;
  logic             ext_rise;
  logic             ext_fall;
  logic             cap_rise;
  logic             cap_fall;
  logic             cap_event;
  logic             cap_acmp_rise;
  logic             cap_acmp_fall;
  logic             wr;
  logic             rd;

  // Fixed values, compare A or capture register as TOP
  function automatic logic [15:0] top_of(input logic [3:0]  mode,
                                          input logic [15:0] cmpa,
                                          input logic [15:0] capt);
    unique case (mode)
      4'h1, 4'h5:                top_of = `STC_TOP_8;
      4'h2, 4'h6:                top_of = `STC_TOP_9;
      4'h3, 4'h7:                top_of = `STC_TOP_10;
      4'h4, 4'h9, 4'hB, 4'hF:    top_of = cmpa;
      4'h8, 4'hA, 4'hC, 4'hE:    top_of = capt;
      default:                   top_of = `STC_MAX;
    endcase
  endfunction : top_of

  function automatic logic is_pwm(input logic [3:0] mode);
    is_pwm = !(mode == 4'h0 || mode == 4'h4 || mode == 4'hC || mode == 4'hD);
  endfunction : is_pwm

  function automatic logic ocra_is_top(input logic [3:0] mode);
    ocra_is_top = (mode == 4'h4 || mode == 4'h9 || mode == 4'hB || mode == 4'hF);
  endfunction : ocra_is_top

  function automatic logic icr_is_top(input logic [3:0] mode);
    icr_is_top = (mode == 4'h8 || mode == 4'hA || mode == 4'hC || mode == 4'hE);
  endfunction : icr_is_top

  stc_pin_cond u_ext_pin (
    .clk      (clk),
    .srst     (srst),
    .pin      (external_count_pin),
    .filt_en  (1'b0),
    .level_ff (),
    .rise_ff  (ext_rise),
    .fall_ff  (ext_fall)
  );

  stc_pin_cond u_cap_pin (
    .clk      (clk),
    .srst     (srst),
    .pin      (capture_input_pin),
    .filt_en  (ctrl_b_ff[`STC_B_CAP_FILT]),
    .level_ff (),
    .rise_ff  (cap_rise),
    .fall_ff  (cap_fall)
  );

  stc_pin_cond u_cap_acmp (
    .clk      (clk),
    .srst     (srst),
    .pin      (comparator_out),
    .filt_en  (ctrl_b_ff[`STC_B_CAP_FILT]),
    .level_ff (),
    .rise_ff  (cap_acmp_rise),
    .fall_ff  (cap_acmp_fall)
  );

  assign wgm      = {ctrl_b_ff[`STC_B_WGM_HI], ctrl_a_ff[`STC_B_WGM_LO]};
  assign top_val  = top_of(wgm, cmp_act_ff[0], capture_reg_ff);
  assign pwm_mode = is_pwm(wgm);
  assign wr       = io_we;
  assign rd       = io_re & ~io_we;
  // channel C absent in legacy mode
  assign chan_en  = {~legacy_mode, 2'b11};

  always_comb begin
    // prescaler held while clear bit stands
    presc_rst  = shared_prescaler_clear_ff
                 | (wr && io_addr == `STC_A_SFC && io_wdata[`STC_B_PCLR]);
    nxt_pre    = presc_rst ? '0 : pre_ff + 1'b1;
    // tick from prescaler tap or pin edge
    unique case (stc_pkg::stc_clk_sel_t'(ctrl_b_ff[`STC_B_CS]))
      stc_pkg::STC_CS_STOP:     timer_tick = 1'b0;
      stc_pkg::STC_CS_DIV1:     timer_tick = 1'b1;
      stc_pkg::STC_CS_DIV8:     timer_tick = &pre_ff[2:0];
      stc_pkg::STC_CS_DIV64:    timer_tick = &pre_ff[5:0];
      stc_pkg::STC_CS_DIV256:   timer_tick = &pre_ff[7:0];
      stc_pkg::STC_CS_DIV1024:  timer_tick = &pre_ff[9:0];
      stc_pkg::STC_CS_EXT_FALL: timer_tick = ext_fall;
      stc_pkg::STC_CS_EXT_RISE: timer_tick = ext_rise;
    endcase
    // no source means no tick; halted timers too
    timer_tick = timer_tick & ~presc_rst;
    cap_event  = ctrl_c_ff[`STC_B_CAP_ACMP]
                 ? (ctrl_b_ff[`STC_B_CAP_EDGE] ? cap_acmp_rise : cap_acmp_fall)
                 : (ctrl_b_ff[`STC_B_CAP_EDGE] ? cap_rise : cap_fall);
  end

  always_comb begin
    nxt_counter_value          = counter_value_ff;
    nxt_temp                   = temp_ff;
    nxt_cmp_buf                = cmp_buf_ff;
    nxt_cmp_act                = cmp_act_ff;
    nxt_capture_reg            = capture_reg_ff;
    nxt_ctrl_a                 = ctrl_a_ff;
    nxt_ctrl_b                 = ctrl_b_ff;
    nxt_ctrl_c                 = ctrl_c_ff;
    nxt_mask                   = mask_ff;
    nxt_sync_hold_mode         = sync_hold_mode_ff;
    nxt_shared_prescaler_clear = shared_prescaler_clear_ff & sync_hold_mode_ff;
    nxt_moved                  = 1'b0;
    nxt_rdata                  = io_rdata_ff;
    nxt_match                  = 3'b000;
    hit                        = 3'b000;
    nxt_pwm                    = compare_output_pins_ff;
    nxt_flag                   = flag_ff & ~irq_ack;

    // Counting; wrap at TOP
    if (timer_tick) begin
      nxt_moved = 1'b1;
      nxt_counter_value = (counter_value_ff == top_val) ? `STC_BOTTOM
                                                        : counter_value_ff + 16'h0001;
      if (counter_value_ff == top_val) begin
        // buffered compare values load at wrap in PWM modes
        if (pwm_mode) begin
          nxt_cmp_act = cmp_buf_ff;
        end
      end
    end

    // compare each enabled channel after every counter move
    for (int i = 0; i < 3; i++) begin
      if (moved_ff && chan_en[i] && counter_value_ff == cmp_act_ff[i]) begin
        hit[i] = 1'b1;
      end
    end
    // Forced compare strobes pulse the match outputs in non-PWM modes only, set no flag and leave the waveform low
    nxt_match = hit | (ctrl_c_ff[`STC_B_FORCE] & chan_en & {3{~pwm_mode}});

    // Simple waveform: set at BOTTOM, clear on match
    for (int i = 0; i < 3; i++) begin
      if (!pwm_mode || !chan_en[i]) begin
        nxt_pwm[i] = 1'b0;
      end else if (moved_ff && counter_value_ff == `STC_BOTTOM) begin
        nxt_pwm[i] = 1'b1;
      end else if (nxt_match[i]) begin
        nxt_pwm[i] = 1'b0;
      end
    end
    // channel A silent when it sets TOP
    if (ocra_is_top(wgm)) begin
      nxt_pwm[0] = 1'b0;
    end
    nxt_ctrl_c[`STC_B_FORCE] = 3'b000;

    // capture counter on edge unless capture register is TOP
    if (cap_event && !icr_is_top(wgm)) begin
      nxt_capture_reg = counter_value_ff;
    end

    // Host reads
    if (rd) begin
      unique case (io_addr)
        `STC_A_CNT_L: begin
          nxt_rdata = counter_value_ff[7:0];
          // low read fills temp same cycle
          nxt_temp  = counter_value_ff[15:8];
        end
        `STC_A_CAP_L: begin
          nxt_rdata = capture_reg_ff[7:0];
          nxt_temp  = capture_reg_ff[15:8];
        end
        // high read returns what low read stored
        `STC_A_CNT_H, `STC_A_CAP_H: nxt_rdata = temp_ff;
        `STC_A_CMPA_L: nxt_rdata = cmp_buf_ff[0][7:0];
        `STC_A_CMPA_H: nxt_rdata = cmp_buf_ff[0][15:8];
        `STC_A_CMPB_L: nxt_rdata = cmp_buf_ff[1][7:0];
        `STC_A_CMPB_H: nxt_rdata = cmp_buf_ff[1][15:8];
        `STC_A_CMPC_L: nxt_rdata = chan_en[2] ? cmp_buf_ff[2][7:0] : `STC_RST_BYTE;
        `STC_A_CMPC_H: nxt_rdata = chan_en[2] ? cmp_buf_ff[2][15:8] : `STC_RST_BYTE;
        `STC_A_CTRL_A: nxt_rdata = ctrl_a_ff;
        `STC_A_CTRL_B: nxt_rdata = ctrl_b_ff;
        `STC_A_CTRL_C: nxt_rdata = ctrl_c_ff;
        `STC_A_FLAG:   nxt_rdata = {3'b000, flag_ff};
        `STC_A_MASK:   nxt_rdata = {3'b000, mask_ff};
        `STC_A_SFC:    nxt_rdata = {sync_hold_mode_ff, 6'b000000,
                                    shared_prescaler_clear_ff};
      endcase
    end

    // Host writes; placed after counting so they override it
    if (wr) begin
      unique case (io_addr)
        `STC_A_CNT_H, `STC_A_CMPA_H, `STC_A_CMPB_H, `STC_A_CMPC_H, `STC_A_CAP_H:
          nxt_temp = io_wdata;
        // host write beats count and clear
        `STC_A_CNT_L: nxt_counter_value = {temp_ff, io_wdata};
        `STC_A_CAP_L: nxt_capture_reg   = {temp_ff, io_wdata};
        `STC_A_CMPA_L, `STC_A_CMPB_L, `STC_A_CMPC_L: begin
          nxt_cmp_buf[io_addr[2:1] - 2'd1] = {temp_ff, io_wdata};
          if (!pwm_mode) begin
            nxt_cmp_act[io_addr[2:1] - 2'd1] = {temp_ff, io_wdata};
          end
        end
        `STC_A_CTRL_A: nxt_ctrl_a = io_wdata;
        `STC_A_CTRL_B: nxt_ctrl_b = io_wdata;
        `STC_A_CTRL_C: nxt_ctrl_c = io_wdata;
        `STC_A_FLAG:   nxt_flag   = nxt_flag & ~io_wdata[4:0];
        `STC_A_MASK:   nxt_mask   = io_wdata[4:0];
        `STC_A_SFC: begin
          nxt_sync_hold_mode = io_wdata[`STC_B_SYNC_HOLD];
          // clear bit survives only while sync mode stays set
          nxt_shared_prescaler_clear = io_wdata[`STC_B_PCLR]
                                       & io_wdata[`STC_B_SYNC_HOLD];
        end
      endcase
    end

    // Hardware sets applied after software clears so they win
    // match flags
    nxt_flag[`STC_F_CMP] = nxt_flag[`STC_F_CMP] | hit;
    if (cap_event && !icr_is_top(wgm)) begin
      nxt_flag[`STC_F_CAP] = 1'b1;
    end
    if (timer_tick && counter_value_ff == top_val) begin
      nxt_flag[`STC_F_OVF] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      counter_value_ff          <= `STC_RST_WORD;
      temp_ff                   <= `STC_RST_BYTE;
      capture_reg_ff            <= `STC_RST_WORD;
      ctrl_a_ff                 <= `STC_RST_BYTE;
      ctrl_b_ff                 <= `STC_RST_BYTE;
      ctrl_c_ff                 <= `STC_RST_BYTE;
      flag_ff                   <= 5'h00;
      mask_ff                   <= 5'h00;
      sync_hold_mode_ff         <= 1'b0;
      shared_prescaler_clear_ff <= 1'b0;
      pre_ff                    <= '0;
      moved_ff                  <= 1'b0;
      io_rdata_ff               <= `STC_RST_BYTE;
      irq_req_ff                <= 5'h00;
      compare_match_ff          <= 3'b000;
      compare_output_pins_ff    <= 3'b000;
      bottom_ff                 <= 1'b0;
      max_ff                    <= 1'b0;
      top_ff                    <= 1'b0;
      for (int i = 0; i < 3; i++) begin
        cmp_buf_ff[i] <= `STC_RST_WORD;
        cmp_act_ff[i] <= `STC_RST_WORD;
      end
    end else begin
      counter_value_ff          <= nxt_counter_value;
      temp_ff                   <= nxt_temp;
      cmp_buf_ff                <= nxt_cmp_buf;
      cmp_act_ff                <= nxt_cmp_act;
      capture_reg_ff            <= nxt_capture_reg;
      ctrl_a_ff                 <= nxt_ctrl_a;
      ctrl_b_ff                 <= nxt_ctrl_b;
      ctrl_c_ff                 <= nxt_ctrl_c;
      flag_ff                   <= nxt_flag;
      mask_ff                   <= nxt_mask;
      sync_hold_mode_ff         <= nxt_sync_hold_mode;
      shared_prescaler_clear_ff <= nxt_shared_prescaler_clear;
      pre_ff                    <= nxt_pre;
      moved_ff                  <= nxt_moved;
      io_rdata_ff               <= nxt_rdata;
      // each request gated by its mask bit
      irq_req_ff                <= nxt_flag & nxt_mask;
      compare_match_ff          <= nxt_match;
      compare_output_pins_ff    <= nxt_pwm;
      bottom_ff                 <= (nxt_counter_value == `STC_BOTTOM);
      max_ff                    <= (nxt_counter_value == `STC_MAX);
      top_ff                    <= (nxt_counter_value == top_val);
    end
  end

endmodule : stc_timer_core

// file: verification/stc_timer_core_sva.sv
`timescale 1ns/1ps
`include "stc_cfg.svh"

module stc_timer_core_sva #(
  parameter int PRE_W = 10
) (
  input wire logic                   clk,
  input wire logic                   srst,
  input wire logic [`STC_ADDR_W-1:0] io_addr,
  input wire logic [7:0]             io_wdata,
  input wire logic                   io_we,
  input wire logic                   io_re,
  input wire logic [7:0]             io_rdata_ff,
  input wire logic                   legacy_mode,
  input wire logic                   external_count_pin,
  input wire logic                   capture_input_pin,
  input wire logic                   comparator_out,
  input wire logic [4:0]             irq_ack,
  input wire logic [4:0]             irq_req_ff,
  input wire logic [2:0]             compare_match_ff,
  input wire logic [2:0]             compare_output_pins_ff,
  input wire logic                   bottom_ff,
  input wire logic                   max_ff,
  input wire logic                   top_ff
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);

  rdata_hold_a: assert property (
    !$stable(io_rdata_ff) |-> $past(io_re && !io_we) || $past(srst))
    else $error("read data moved without a read");
  bounds_excl_a: assert property (!(bottom_ff && max_ff))
    else $error("bottom and max both high");
  legacy_c_a: assert property (
    legacy_mode [*3] |-> compare_match_ff[2] == 1'b0 && compare_output_pins_ff[2] == 1'b0)
    else $error("channel C active in legacy mode");
  match_pulse_a: assert property (compare_match_ff[0] |=> !compare_match_ff[0])
    else $error("match A longer than one cycle");
  match_b_pulse_a: assert property (
    $rose(compare_match_ff[1]) |=> $fell(compare_match_ff[1]))
    else $error("match B longer than one cycle");
  ack_clear_a: assert property (
    irq_ack[1] [*2] ##0 !compare_match_ff[0] |=> !irq_req_ff[1] || compare_match_ff[0])
    else $error("acknowledge did not clear request A");
  irq_a_rise_a: assert property (
    $rose(irq_req_ff[1]) |-> compare_match_ff[0] || $past(compare_match_ff[0])
      || $past(io_we) || $past(io_we, 2))
    else $error("request A rose without cause");
  irq_b_rise_a: assert property (
    $rose(irq_req_ff[2]) |-> compare_match_ff[1] || $past(compare_match_ff[1])
      || $past(io_we) || $past(io_we, 2))
    else $error("request B rose without cause");
endmodule : stc_timer_core_sva

bind stc_timer_core stc_timer_core_sva #(.PRE_W(PRE_W)) u_sva (
  .clk(clk), .srst(srst), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
  .io_re(io_re), .io_rdata_ff(io_rdata_ff), .legacy_mode(legacy_mode),
  .external_count_pin(external_count_pin), .capture_input_pin(capture_input_pin),
  .comparator_out(comparator_out), .irq_ack(irq_ack), .irq_req_ff(irq_req_ff),
  .compare_match_ff(compare_match_ff), .compare_output_pins_ff(compare_output_pins_ff),
  .bottom_ff(bottom_ff), .max_ff(max_ff), .top_ff(top_ff)
);

// file: verification/stc_host_model.sv
`timescale 1ns/1ps
`include "stc_cfg.svh"

module stc_host_model (
  input wire logic              clk,
  output logic [`STC_ADDR_W-1:0] io_addr,
  output logic [7:0]             io_wdata,
  output logic                   io_we,
  output logic                   io_re,
  input wire logic [7:0]         io_rdata_ff
);
  initial begin
    io_addr = '0;
    io_wdata = 8'h00;
    io_we = 1'b0;
    io_re = 1'b0;
  end

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_wdata = d;
    io_we = 1'b1;
    @(posedge clk);
    #1;
    io_we = 1'b0;
    // Idle bus shows stale-inverted values, never a lucky match
    io_addr = ~a;
    io_wdata = ~d;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    io_addr = a;
    io_re = 1'b1;
    @(posedge clk);
    #1;
    io_re = 1'b0;
    io_addr = ~a;
    @(posedge clk);
    #1;
    d = io_rdata_ff;
  endtask : rd

  task automatic wr16(input logic [3:0] a, input logic [15:0] v);
    wr(a + 4'h1, v[15:8]);
    wr(a, v[7:0]);
  endtask : wr16

  task automatic rd16(input logic [3:0] a, output logic [15:0] v);
    rd(a, v[7:0]);
    rd(a + 4'h1, v[15:8]);
  endtask : rd16
endmodule : stc_host_model

// file: verification/tb_top.sv
`timescale 1ns/1ps
`include "stc_cfg.svh"

module tb_top;
  logic                   clk = 1'b0;
  logic                   srst = 1'b1;
  logic [`STC_ADDR_W-1:0] io_addr;
  logic [7:0]             io_wdata;
  logic                   io_we;
  logic                   io_re;
  logic [7:0]             io_rdata_ff;
  logic                   legacy_mode = 1'b0;
  logic                   ext_pin = 1'b0;
  logic                   cap_pin = 1'b0;
  logic                   cmp_out = 1'b0;
  logic [4:0]             irq_ack = 5'h00;
  logic [4:0]             irq_req_ff;
  logic                   bot;
  logic                   mx;
  logic                   tp;
  logic [2:0]             pins;
  logic [7:0]             d;
  logic [15:0]            w;
  int                     err_total = 0;
  int                     n_tests = 0;

  always #20 clk = ~clk;

  stc_timer_core DUT (
    .clk(clk), .srst(srst), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we),
    .io_re(io_re), .io_rdata_ff(io_rdata_ff), .legacy_mode(legacy_mode),
    .external_count_pin(ext_pin), .capture_input_pin(cap_pin), .comparator_out(cmp_out),
    .irq_ack(irq_ack), .irq_req_ff(irq_req_ff), .compare_match_ff(),
    .compare_output_pins_ff(pins), .bottom_ff(bot), .max_ff(mx), .top_ff(tp)
  );

  stc_host_model h (
    .clk(clk), .io_addr(io_addr), .io_wdata(io_wdata), .io_we(io_we), .io_re(io_re),
    .io_rdata_ff(io_rdata_ff)
  );

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic stop_test();
    $display("Comparisons %0d, mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  initial begin
    tick(4);
    srst = 1'b0;
    for (int a = 10; a < 16; a++) begin
      h.rd(a[3:0], d);
      chk({8'h00, d}, 16'h0000);
    end
    h.wr(`STC_A_MASK, 8'h1F);
    h.rd(`STC_A_MASK, d);
    chk({8'h00, d}, 16'h001F);
    h.wr(`STC_A_CTRL_C, 8'h01);
    h.rd(`STC_A_CTRL_C, d);
    chk({8'h00, d}, 16'h0001);
    // Stopped counter keeps what was written
    h.wr16(`STC_A_CNT_L, 16'h01FF);
    tick(5);
    h.rd16(`STC_A_CNT_L, w);
    chk(w, 16'h01FF);
    h.wr(`STC_A_CNT_H, 8'hAB);
    h.rd16(`STC_A_CNT_L, w);
    chk(w, 16'h01FF);
    h.wr16(`STC_A_CMPA_L, 16'h0005);
    h.wr16(`STC_A_CMPB_L, 16'h0008);
    h.wr16(`STC_A_CMPC_L, 16'h0020);
    // Temp byte must survive a compare B low read followed by a compare A high read
    h.wr(`STC_A_CNT_H, 8'h55);
    h.rd(`STC_A_CMPB_L, d);
    chk({8'h00, d}, 16'h0008);
    h.rd(`STC_A_CMPA_H, d);
    chk({8'h00, d}, 16'h0000);
    h.wr(`STC_A_CNT_L, 8'h00);
    h.rd16(`STC_A_CNT_L, w);
    chk(w, 16'h5500);
    legacy_mode = 1'b1;
    tick(3);
    h.rd(`STC_A_CMPC_L, d);
    chk({8'h00, d}, 16'h0000);
    legacy_mode = 1'b0;
    h.rd(`STC_A_CMPC_L, d);
    chk({8'h00, d}, 16'h0020);
    h.wr16(`STC_A_CNT_L, 16'h0000);
    h.wr(`STC_A_CTRL_B, 8'h01);
    tick(40);
    h.rd(`STC_A_FLAG, d);
    chk({8'h00, d}, 16'h000E);
    chk({11'h000, irq_req_ff}, 16'h000E);
    irq_ack = 5'h02;
    tick(2);
    irq_ack = 5'h00;
    h.rd(`STC_A_FLAG, d);
    chk({8'h00, d}, 16'h000C);
    h.wr(`STC_A_FLAG, 8'h04);
    h.rd(`STC_A_FLAG, d);
    chk({8'h00, d}, 16'h0008);
    h.wr(`STC_A_MASK, 8'h00);
    tick(3);
    chk({11'h000, irq_req_ff}, 16'h0000);
    h.wr(`STC_A_MASK, 8'h1F);
    // Halt by sync hold, then capture exact counter values
    h.wr(`STC_A_SFC, 8'h81);
    h.wr16(`STC_A_CNT_L, 16'h0ABC);
    tick(10);
    h.rd16(`STC_A_CNT_L, w);
    chk(w, 16'h0ABC);
    h.rd(`STC_A_SFC, d);
    chk({8'h00, d}, 16'h0081);
    h.wr(`STC_A_CTRL_C, 8'h00);
    h.wr(`STC_A_CTRL_B, 8'h41);
    h.rd(`STC_A_CTRL_B, d);
    chk({8'h00, d}, 16'h0041);
    cap_pin = 1'b1;
    tick(10);
    h.rd16(`STC_A_CAP_L, w);
    chk(w, 16'h0ABC);
    h.rd(`STC_A_FLAG, d);
    chk({8'h00, d}, 16'h0009);
    h.wr(`STC_A_CTRL_C, 8'h01);
    h.wr16(`STC_A_CNT_L, 16'h0DEF);
    cmp_out = 1'b1;
    tick(10);
    h.rd16(`STC_A_CAP_L, w);
    chk(w, 16'h0DEF);
    h.wr(`STC_A_FLAG, 8'h01);
    h.rd(`STC_A_FLAG, d);
    chk({8'h00, d}, 16'h0008);
    h.wr(`STC_A_SFC, 8'h00);
    h.rd(`STC_A_SFC, d);
    chk({8'h00, d}, 16'h0000);
    h.rd16(`STC_A_CNT_L, w);
    chk({15'h0000, w > 16'h0DEF && w < 16'h0E03}, 16'h0001);
    h.wr16(`STC_A_CNT_L, 16'h3000);
    h.rd16(`STC_A_CNT_L, w);
    chk({15'h0000, w > 16'h3000 && w < 16'h3010}, 16'h0001);
    h.wr(`STC_A_CTRL_B, 8'h07);
    h.wr16(`STC_A_CNT_L, 16'h0000);
    repeat (3) begin
      ext_pin = 1'b1;
      tick(6);
      ext_pin = 1'b0;
      tick(6);
    end
    h.rd16(`STC_A_CNT_L, w);
    chk(w, 16'h0003);
    // Stopped counter: bound flags follow each written value
    h.wr(`STC_A_CTRL_B, 8'h00);
    h.wr16(`STC_A_CNT_L, 16'hFFFF);
    chk({13'h0000, bot, mx, tp}, 16'h0003);
    h.wr16(`STC_A_CNT_L, 16'h0000);
    chk({13'h0000, bot, mx, tp}, 16'h0004);
    h.wr(`STC_A_CTRL_A, 8'h02);
    h.wr16(`STC_A_CNT_L, 16'h01FF);
    chk({13'h0000, bot, mx, tp}, 16'h0001);
    // Compare A as TOP: new TOP below counter only lands at wrap
    h.wr(`STC_A_CTRL_A, 8'h03);
    h.wr(`STC_A_CTRL_B, 8'h18);
    h.wr16(`STC_A_CNT_L, 16'h0003);
    h.wr16(`STC_A_CMPA_L, 16'h0002);
    h.wr(`STC_A_CTRL_B, 8'h19);
    tick(20);
    h.wr(`STC_A_CTRL_B, 8'h18);
    h.rd16(`STC_A_CNT_L, w);
    chk({15'h0000, w < 16'h0003}, 16'h0001);
    chk({13'h0000, pins}, 16'h0006);
    stop_test();
  end

  initial begin
    repeat (5000) @(posedge clk);
    err_total++;
    $display("MISMATCH at %0t: run did not finish", $time);
    stop_test();
  end
endmodule : tb_top
